// ==== verilog/phy_port_control_logic.sv ====
// What this block does
// - autoneg off: force speed, duplex from control
// - half duplex: carrier on transmit or receive
// - half duplex: receive while transmitting collides
// - full duplex: carrier on receive, no collision
// - override set: crossover from register bits
// - override clear: auto crossover from strap
// - both low: manual strap fixes pairs
// - receive clock recovered, else reference derived
// - serve registers 0 to 6 and vendor
// - unimplemented register reads return ffff
// - source read reports and clears interrupt
// - mask gates sources, or into one
// - interrupt bits energy 7 down to page 1
// - general power-down keeps all but management off
// - leaving power-down resets the phy core
// - external interface select forces power-down
// - energy power-down: off without line energy
// - energy return: wake, self-reset, flag bit 7
// - power-down never touches registers
// - chip digital reset leaves phy alone
// - straps load only on hardware reset, reload
// - restart autoneg bit restarts it anytime
`timescale 1ns/1ps
`default_nettype none
`include "phy_defines.svh"
module phy_port_control_logic #(
   parameter logic [15:0] ID_HI = 16'h1234,   // arbitrary identity value
   parameter logic [15:0] ID_LO = 16'h5670    // arbitrary identity value
) (
   // clock, reset, enable
   input  wire logic        mclk_in,
   input  wire logic        rstn_in,
   input  wire logic        ce_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic             pready_out,
   output logic [31:0]      prdata_out,
   output logic             pslverr_out,
   // straps and system controls
   input  wire logic        strap_an_en_in,
   input  wire logic        strap_speed_in,
   input  wire logic        strap_duplex_in,
   input  wire logic        auto_mdix_strap_in,
   input  wire logic        manual_mdix_strap_in,
   input  wire logic        strap_reload_in,
   input  wire logic        ext_mii_sel_in,
   // analog core and autoneg engine
   input  wire logic        line_energy_in,
   input  wire logic        link_up_in,
   input  wire logic        an_done_in,
   input  wire logic        an_speed_in,
   input  wire logic        an_duplex_in,
   input  wire logic [15:0] an_lp_ability_in,
   input  wire logic [15:0] an_expansion_in,
   input  wire logic [6:1]  core_event_in,
   output logic             core_enable_out,
   output logic             core_reset_out,
   output logic             an_restart_out,
   output logic             auto_xo_enable_out,
   output logic             fixed_swap_out,
   output logic             speed_100_out,
   output logic             full_duplex_out,
   output logic             port_irq_out,
   // mac side mii
   input  wire logic        tx_en_in,
   input  wire logic [3:0]  txd_in,
   output logic             crs_out,
   output logic             col_out,
   output logic             rx_dv_out,
   output logic [3:0]       rxd_out,
   output logic             rx_clk_out,
   // line side data
   input  wire logic        line_signal_in,
   input  wire logic        line_rx_clk_in,
   input  wire logic        line_rx_dv_in,
   input  wire logic [3:0]  line_rxd_in,
   output logic             line_tx_en_out,
   output logic [3:0]       line_txd_out
);
   port_cfg_if cfg ();
   phy_pkg::ctl_state_t s, n;
   logic wr_acc, rd_setup, hold_down, soft_rst;

   // ==================================================
   // submodules
   irq_flags u_irq (
      .mclk_in (mclk_in),
      .rstn_in (rstn_in),
      .cfg     (cfg.flags)
   );
   duplex_mii u_mii (
      .mclk_in        (mclk_in),
      .rstn_in        (rstn_in),
      .cfg            (cfg.mii),
      .tx_en_in       (tx_en_in),
      .txd_in         (txd_in),
      .crs_out        (crs_out),
      .col_out        (col_out),
      .rx_dv_out      (rx_dv_out),
      .rxd_out        (rxd_out),
      .rx_clk_out     (rx_clk_out),
      .line_signal_in (line_signal_in),
      .line_rx_clk_in (line_rx_clk_in),
      .line_rx_dv_in  (line_rx_dv_in),
      .line_rxd_in    (line_rxd_in),
      .line_tx_en_out (line_tx_en_out),
      .line_txd_out   (line_txd_out)
   );

   // ==================================================
   // glue to submodules
   assign cfg.ce = ce_in;
   assign cfg.full_duplex = s.duplex_eff;
   assign cfg.speed_100 = s.speed_eff;
   assign cfg.link_active = (s.pwr == phy_pkg::PWR_ON);
   assign cfg.mask = s.mask;
   // energy on top, core events below
   assign cfg.event_pulse = {line_energy_in & ~s.energy_q & s.straps_done, core_event_in};
   // read of source register clears flags
   assign cfg.rd_clear = rd_setup & (paddr_in == `OFS_IRQ_SRC); // same edge as capture

   // ==================================================
   // apb decode: zero wait states, data captured in setup
   assign wr_acc = psel_in & penable_in & pwrite_in;
   assign rd_setup = psel_in & ~penable_in & ~pwrite_in;
   assign soft_rst = wr_acc & (paddr_in == `OFS_BASIC_CTRL) & pwdata_in[`BC_SOFT_RST];

   // ==================================================
   // next state of registers and sequencer
   always_comb begin
      n = s;
      n.an_restart = 1'b0;
      n.energy_q = line_energy_in;
      // straps only at hardware reset release or reload
      // no other reset source reaches this logic
      if (!s.straps_done || strap_reload_in) begin
         n.an_en = strap_an_en_in;
         n.speed = strap_speed_in;
         n.duplex = strap_duplex_in;
         n.straps_done = 1'b1;
      end
      // register writes
      if (wr_acc) begin
         case (paddr_in)
            `OFS_BASIC_CTRL: begin
               n.speed = pwdata_in[`BC_SPEED];
               n.an_en = pwdata_in[`BC_AN_EN];
               n.pdown = pwdata_in[`BC_PDOWN];
               n.duplex = pwdata_in[`BC_DUPLEX];
               n.an_restart = pwdata_in[`BC_RESTART_AN];
            end
            `OFS_AN_ADV: begin
               n.adv = pwdata_in[15:0];
            end
            `OFS_MODE_CTRL: begin
               n.edpd = pwdata_in[`MC_EDPD];
            end
            `OFS_SPECIAL: begin
               n.xo_ctrl = pwdata_in[`SC_XO_CTRL];
               n.xo_en = pwdata_in[`SC_XO_EN];
               n.xo_state = pwdata_in[`SC_XO_STATE];
            end
            `OFS_IRQ_MASK: begin
               n.mask = pwdata_in[7:1];
            end
            default: begin
               n.adv = s.adv;
            end
         endcase
      end
      // soft reset takes plain defaults, straps are not reloaded
      if (soft_rst) begin
         n.speed = 1'b1;
         n.an_en = 1'b1;
         n.duplex = 1'b0;
         n.pdown = 1'b0;
         n.adv = `ADV_DEF;
         n.mask = 7'h00;
         n.edpd = 1'b0;
         n.xo_ctrl = 1'b0;
         n.xo_en = 1'b0;
         n.xo_state = 1'b0;
      end
      hold_down = n.pdown | ext_mii_sel_in;
      case (s.pwr)
         phy_pkg::PWR_ON: begin
            if (hold_down) begin
               n.pwr = phy_pkg::PWR_GEN;
            end else if (soft_rst) begin
               n.pwr = phy_pkg::PWR_RST;
               n.rst_cnt = 8'(`PHY_RST_CYC - 1);
            end else if (s.edpd && !line_energy_in) begin
               n.pwr = phy_pkg::PWR_ED;
            end
         end
         phy_pkg::PWR_GEN: begin
            if (!hold_down) begin
               n.pwr = phy_pkg::PWR_RST;
               n.rst_cnt = 8'(`PHY_RST_CYC - 1);
            end
         end
         phy_pkg::PWR_ED: begin
            // energy return wakes through a reset
            if (hold_down) begin
               n.pwr = phy_pkg::PWR_GEN;
            end else if (line_energy_in || !n.edpd || soft_rst) begin
               n.pwr = phy_pkg::PWR_RST;
               n.rst_cnt = 8'(`PHY_RST_CYC - 1);
            end
         end
         phy_pkg::PWR_RST: begin
            if (hold_down) begin
               n.pwr = phy_pkg::PWR_GEN;
            end else if (soft_rst) begin
               n.rst_cnt = 8'(`PHY_RST_CYC - 1);
            end else if (s.rst_cnt == 8'h00) begin
               // core comes back and negotiates afresh
               n.pwr = phy_pkg::PWR_ON;
               n.an_restart = 1'b1;
            end else begin
               n.rst_cnt = s.rst_cnt - 8'h01;
            end
         end
         default: begin
            n.pwr = phy_pkg::PWR_RST;
            n.rst_cnt = 8'(`PHY_RST_CYC - 1);
         end
      endcase
      if (n.xo_ctrl) begin
         n.auto_xo = n.xo_en;
         n.fixed_swap = n.xo_state;
      end else begin
         n.auto_xo = auto_mdix_strap_in;
         n.fixed_swap = manual_mdix_strap_in;
      end
      // forced bits apply only with autoneg off
      n.speed_eff = n.an_en ? an_speed_in : n.speed;
      n.duplex_eff = n.an_en ? an_duplex_in : n.duplex;
      // read data, unmapped words read ffff
      if (rd_setup) begin
         case (paddr_in)
            `OFS_BASIC_CTRL: begin
               n.prdata = '0;
               n.prdata[`BC_SPEED] = s.speed;
               n.prdata[`BC_AN_EN] = s.an_en;
               n.prdata[`BC_PDOWN] = s.pdown;
               n.prdata[`BC_DUPLEX] = s.duplex;
            end
            `OFS_BASIC_STAT: begin
               n.prdata = '0;
               n.prdata[`BS_AN_DONE] = an_done_in;
               n.prdata[`BS_LINK] = link_up_in & (s.pwr == phy_pkg::PWR_ON);
            end
            `OFS_ID_HI: begin
               n.prdata = {16'h0000, ID_HI};
            end
            `OFS_ID_LO: begin
               n.prdata = {16'h0000, ID_LO};
            end
            `OFS_AN_ADV: begin
               n.prdata = {16'h0000, s.adv};
            end
            `OFS_AN_LP: begin
               n.prdata = {16'h0000, an_lp_ability_in};
            end
            `OFS_AN_EXP: begin
               n.prdata = {16'h0000, an_expansion_in};
            end
            `OFS_MODE_CTRL: begin
               n.prdata = '0;
               n.prdata[`MC_EDPD] = s.edpd;
               n.prdata[`MC_ENERGY] = s.energy_q;
            end
            `OFS_SPECIAL: begin
               n.prdata = '0;
               n.prdata[`SC_XO_CTRL] = s.xo_ctrl;
               n.prdata[`SC_XO_EN] = s.xo_en;
               n.prdata[`SC_XO_STATE] = s.xo_state;
            end
            `OFS_IRQ_SRC: begin
               n.prdata = {24'h000000, cfg.src, 1'b0};
            end
            `OFS_IRQ_MASK: begin
               n.prdata = {24'h000000, s.mask, 1'b0};
            end
            default: begin
               n.prdata = `UNMAPPED_DATA;
            end
         endcase
      end
   end

   // ==================================================
   // state register; straps are caught after release, not under reset
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s <= '{adv: `ADV_DEF, an_en: 1'b1, speed: 1'b1, pwr: phy_pkg::PWR_RST,
                rst_cnt: 8'(`PHY_RST_CYC - 1), default: '0};
      end else if (ce_in) begin
         s <= n;
      end
   end

   // ==================================================
   // outputs
   assign pready_out = 1'b1;
   assign pslverr_out = 1'b0;
   assign prdata_out = s.prdata;
   assign core_enable_out = (s.pwr == phy_pkg::PWR_ON);
   assign core_reset_out = (s.pwr == phy_pkg::PWR_RST);
   assign an_restart_out = s.an_restart;
   assign auto_xo_enable_out = s.auto_xo;
   assign fixed_swap_out = s.fixed_swap;
   assign speed_100_out = s.speed_eff;
   assign full_duplex_out = s.duplex_eff;
   assign port_irq_out = cfg.irq;

   // ==================================================
   // checks
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);

   property p_forced;
      ce_in && !n.an_en |=> speed_100_out == s.speed && full_duplex_out == s.duplex;
   endproperty
   a_forced: assert property (p_forced) else $error("forced speed or duplex wrong");

   property p_pdown_hold;
      s.pdown && !soft_rst && ce_in ##1 s.pdown |-> !core_enable_out;
   endproperty
   a_pdown_hold: assert property (p_pdown_hold) else $error("core on in power-down");

   property p_wake_reset;
      ce_in && s.pwr == phy_pkg::PWR_GEN && !hold_down |=> core_reset_out;
   endproperty
   a_wake_reset: assert property (p_wake_reset) else $error("no reset on wake");

   property p_ext_sel;
      ce_in && ext_mii_sel_in |=> s.pwr == phy_pkg::PWR_GEN;
   endproperty
   a_ext_sel: assert property (p_ext_sel) else $error("external select not powered down");

   property p_unmapped;
      ce_in && rd_setup && paddr_in == 8'h20 |=> prdata_out == `UNMAPPED_DATA;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not ffff");

   property p_energy_flag;
      ce_in && s.pwr == phy_pkg::PWR_ED && line_energy_in && !s.energy_q && !hold_down
         |=> core_reset_out && cfg.src[`IRQ_ENERGY];
   endproperty
   a_energy_flag: assert property (p_energy_flag) else $error("energy wake wrong");

   property p_regs_kept;
      ce_in && !wr_acc && s.straps_done && !strap_reload_in && s.pwr != n.pwr
         |=> $stable(s.mask) && $stable(s.adv);
   endproperty
   a_regs_kept: assert property (p_regs_kept) else $error("power change hit registers");

   property p_restart;
      ce_in && wr_acc && paddr_in == `OFS_BASIC_CTRL && pwdata_in[`BC_RESTART_AN]
         |=> an_restart_out;
   endproperty
   a_restart: assert property (p_restart) else $error("restart not pulsed");

   c_ed_wake: cover property (s.pwr == phy_pkg::PWR_ED ##[1:50] s.pwr == phy_pkg::PWR_ON);
   c_gen_down: cover property (s.pwr == phy_pkg::PWR_GEN ##1 s.pwr == phy_pkg::PWR_RST);
   c_irq: cover property (port_irq_out ##1 cfg.rd_clear ##1 !port_irq_out);
endmodule
`default_nettype wire

// ==== verilog/phy_defines.svh ====
`ifndef PHY_DEFINES_SVH
`define PHY_DEFINES_SVH
// ==================================================
// register byte offsets (word index = management register number)
`define OFS_BASIC_CTRL   8'h00
`define OFS_BASIC_STAT   8'h04
`define OFS_ID_HI        8'h08
`define OFS_ID_LO        8'h0c
`define OFS_AN_ADV       8'h10
`define OFS_AN_LP        8'h14
`define OFS_AN_EXP       8'h18
`define OFS_MODE_CTRL    8'h44
`define OFS_SPECIAL      8'h6c
`define OFS_IRQ_SRC      8'h74
`define OFS_IRQ_MASK     8'h78
`define UNMAPPED_DATA    32'h0000ffff
// ==================================================
// field positions
`define BC_SOFT_RST      15
`define BC_SPEED         13
`define BC_AN_EN         12
`define BC_PDOWN         11
`define BC_RESTART_AN    9
`define BC_DUPLEX        8
`define BS_AN_DONE       5
`define BS_LINK          2
`define MC_EDPD          13
`define MC_ENERGY        1
`define SC_XO_CTRL       15
`define SC_XO_EN         14
`define SC_XO_STATE      13
`define IRQ_ENERGY       7
// ==================================================
// reset values and timing
`define ADV_DEF          16'h01e1
`define CLK_PERIOD_NS    5
`define RX_HALF_100_NS   20
`define RX_HALF_10_NS    200
`define PHY_RST_NS       100
`define RX_HALF_100_CYC  (`RX_HALF_100_NS / `CLK_PERIOD_NS)
`define RX_HALF_10_CYC   (`RX_HALF_10_NS / `CLK_PERIOD_NS)
`define PHY_RST_CYC      ((`PHY_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== verilog/phy_pkg.sv ====
`default_nettype none
package phy_pkg;
   // power and reset sequencer, one-hot
   typedef enum logic [3:0] {
      PWR_ON   = 4'h1,
      PWR_GEN  = 4'h2,
      PWR_ED   = 4'h4,
      PWR_RST  = 4'h8
   } pwr_state_t;
   typedef struct packed {
      logic [15:0] adv;
      logic        speed, duplex, an_en, pdown;
      logic        xo_ctrl, xo_en, xo_state, edpd;
      logic [7:1]  mask;
      pwr_state_t  pwr;
      logic [7:0]  rst_cnt;
      logic        straps_done, energy_q, an_restart;
      logic        auto_xo, fixed_swap, speed_eff, duplex_eff;
      logic [31:0] prdata;
   } ctl_state_t;
   typedef struct packed {
      logic [7:1] src;
      logic       irq;
   } irq_state_t;
   typedef struct packed {
      logic       crs, col, tx_en, rx_dv, rx_clk;
      logic [3:0] txd, rxd;
      logic [5:0] div_cnt;
   } mii_state_t;
endpackage
`default_nettype wire

// ==== verilog/port_cfg_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface port_cfg_if;
   logic       ce, full_duplex, speed_100, link_active;
   logic [7:1] event_pulse, mask, src;
   logic       rd_clear, irq;
   modport ctrl  (output ce, full_duplex, speed_100, link_active, event_pulse, mask, rd_clear,
                  input src, irq);
   modport mii   (input ce, full_duplex, speed_100, link_active);
   modport flags (input ce, event_pulse, mask, rd_clear, output src, irq);
endinterface
`default_nettype wire

// ==== verilog/irq_flags.sv ====
`timescale 1ns/1ps
`default_nettype none
module irq_flags (
   // clock and reset
   input  wire logic   mclk_in,
   input  wire logic   rstn_in,
   // control side
   port_cfg_if.flags   cfg
);
   phy_pkg::irq_state_t s, n;
   // ==================================================
   // sticky flags, set beats the read clear
   always_comb begin
      n = s;
      n.src = (cfg.rd_clear ? 7'h00 : s.src) | cfg.event_pulse;
      n.irq = |(n.src & cfg.mask);
   end
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s <= '0;
      end else if (cfg.ce) begin
         s <= n;
      end
   end
   assign cfg.src = s.src;
   assign cfg.irq = s.irq;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   property p_set_wins;
      cfg.ce && cfg.rd_clear && cfg.event_pulse[1] |=> cfg.src[1];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost on clear");
   property p_read_clears;
      cfg.ce && cfg.rd_clear && cfg.event_pulse == 7'h00 |=> !cfg.irq && cfg.src == 7'h00;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("read did not clear");
endmodule
`default_nettype wire

// ==== verilog/duplex_mii.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "phy_defines.svh"
module duplex_mii (
   // clock and reset
   input  wire logic       mclk_in,
   input  wire logic       rstn_in,
   // configuration
   port_cfg_if.mii         cfg,
   // mac side
   input  wire logic       tx_en_in,
   input  wire logic [3:0] txd_in,
   output logic            crs_out,
   output logic            col_out,
   output logic            rx_dv_out,
   output logic [3:0]      rxd_out,
   output logic            rx_clk_out,
   // line side
   input  wire logic       line_signal_in,
   input  wire logic       line_rx_clk_in,
   input  wire logic       line_rx_dv_in,
   input  wire logic [3:0] line_rxd_in,
   output logic            line_tx_en_out,
   output logic [3:0]      line_txd_out
);
   phy_pkg::mii_state_t s, n;
   logic tx_act, rx_act;
   // ==================================================
   // carrier, collision and data path
   always_comb begin
      n = s;
      tx_act = tx_en_in & cfg.link_active;
      rx_act = line_rx_dv_in & cfg.link_active;
      // full duplex: receive only, no collision
      n.crs = cfg.full_duplex ? rx_act : (tx_act | rx_act);
      n.col = ~cfg.full_duplex & tx_act & rx_act;
      n.tx_en = tx_act;
      n.txd = tx_act ? txd_in : 4'h0;
      n.rx_dv = rx_act;
      n.rxd = rx_act ? line_rxd_in : 4'h0;
      if (line_signal_in) begin
         n.rx_clk = line_rx_clk_in;
         n.div_cnt = '0;
      end else if (s.div_cnt == 6'h00) begin
         n.rx_clk = ~s.rx_clk;
         n.div_cnt = cfg.speed_100 ? 6'(`RX_HALF_100_CYC - 1) : 6'(`RX_HALF_10_CYC - 1);
      end else begin
         n.div_cnt = s.div_cnt - 6'h01;
      end
   end
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s <= '0;
      end else if (cfg.ce) begin
         s <= n;
      end
   end
   assign crs_out = s.crs;
   assign col_out = s.col;
   assign rx_dv_out = s.rx_dv;
   assign rxd_out = s.rxd;
   assign rx_clk_out = s.rx_clk;
   assign line_tx_en_out = s.tx_en;
   assign line_txd_out = s.txd;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   property p_fd_no_col;
      cfg.ce && cfg.full_duplex |=> !col_out;
   endproperty
   a_fd_no_col: assert property (p_fd_no_col) else $error("collision in full duplex");
   property p_hd_col;
      cfg.ce && !cfg.full_duplex && cfg.link_active && tx_en_in && line_rx_dv_in
         |=> col_out && crs_out;
   endproperty
   a_hd_col: assert property (p_hd_col) else $error("half duplex collision missed");
endmodule
`default_nettype wire

// ==== dv/mac_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// switch mac transmit side
module mac_model (
   // clock and reset
   input  wire logic  mclk_in,
   input  wire logic  rstn_in,
   // control
   input  wire logic  go_in,
   // mii transmit
   output logic       tx_en_out,
   output logic [3:0] txd_out
);
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tx_en_out <= 1'b0;
         txd_out   <= 4'h0;
      end else begin
         tx_en_out <= go_in;
         txd_out   <= go_in ? txd_out + 4'h1 : ~txd_out; // idle data never stale
      end
   end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench top
module testbench;
   logic        clk, rstn, psel, pen, pwr, go, rl, ext, nrg, sig, rck, rdv;
   logic        amx, mmx, st, rdy, err, cen, crst, anr, axo, fsw, s100, fdx;
   logic        irq, crs, col, rxdv, rxc, ltx, txe, ena;
   logic [7:0]  paddr;
   logic [31:0] wd, rd, q;
   logic [6:1]  ev;
   logic [3:0]  txd, rxd, ltxd;
   int          mismatches, comparisons, cycles;
   phy_port_control_logic dut (.mclk_in(clk), .rstn_in(rstn), .ce_in(ena),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(wd), .pready_out(rdy), .prdata_out(rd), .pslverr_out(err),
      .strap_an_en_in(1'b0 ^ st), .strap_speed_in(~st), .strap_duplex_in(st),
      .auto_mdix_strap_in(amx), .manual_mdix_strap_in(mmx), .strap_reload_in(rl),
      .ext_mii_sel_in(ext), .line_energy_in(nrg), .link_up_in(st), .an_done_in(st),
      .an_speed_in(st), .an_duplex_in(st), .an_lp_ability_in(16'h0000),
      .an_expansion_in(16'h0000), .core_event_in(ev), .core_enable_out(cen),
      .core_reset_out(crst), .an_restart_out(anr), .auto_xo_enable_out(axo),
      .fixed_swap_out(fsw), .speed_100_out(s100), .full_duplex_out(fdx),
      .port_irq_out(irq), .tx_en_in(txe), .txd_in(txd), .crs_out(crs), .col_out(col),
      .rx_dv_out(rxdv), .rxd_out(rxd), .rx_clk_out(rxc), .line_signal_in(sig),
      .line_rx_clk_in(rck), .line_rx_dv_in(rdv), .line_rxd_in(txd),
      .line_tx_en_out(ltx), .line_txd_out(ltxd));
   mac_model mac (.mclk_in(clk), .rstn_in(rstn), .go_in(go), .tx_en_out(txe), .txd_out(txd));
   // ==========
   // helpers
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      wd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      q = rd;
      chk(32'(err), 32'h0);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic w3;
      repeat (3) @(posedge clk);
   endtask
   task automatic end_sim;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         mismatches++;
         end_sim();
      end
   end
   // ==========
   // main sequence
   initial begin
      {rstn, psel, pen, pwr, go, rl, ext, nrg, sig, rck, rdv, mmx, st} = '0;
      {paddr, wd, ev} = '0;
      {amx, ena} = 2'b11;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      repeat (30) @(posedge clk);
      apb(1'b0, 8'h00, 32'h0); chk(q, 32'h2000);
      apb(1'b0, 8'h10, 32'h0); chk(q, 32'h01e1);
      apb(1'b0, 8'h08, 32'h0); chk(q, 32'h1234);
      chk(32'({s100, fdx}), 32'h2);
      apb(1'b1, 8'h00, 32'h0100); w3(); chk(32'({s100, fdx}), 32'h1);
      go <= 1'b1;
      w3(); chk(32'({crs, col, ltx}), 32'h1);
      rdv <= 1'b1;
      w3(); chk(32'({crs, col}), 32'h2);
      chk(32'({rxdv, rxd, ltxd}), 32'({1'b1, 4'(txd - 4'h1), 4'(txd - 4'h1)}));
      apb(1'b1, 8'h00, 32'h2000); w3(); chk(32'({crs, col}), 32'h3);
      rdv <= 1'b0;
      w3(); chk(32'({crs, col}), 32'h2);
      go <= 1'b0;
      apb(1'b0, 8'h20, 32'h0); chk(q, 32'h0000ffff);
      apb(1'b1, 8'h00, 32'h2200);
      @(negedge clk);
      chk(32'(anr), 32'h1);
      sig <= 1'b1;
      rck <= 1'b1;
      w3(); chk(32'(rxc), 32'h1);
      rck <= 1'b0;
      w3(); chk(32'(rxc), 32'h0);
      sig <= 1'b0;
      w3();
      q = 32'(rxc);
      repeat (4) @(posedge clk);
      chk(32'(q[0] ^ rxc), 32'h1);
      ena <= 1'b0;
      @(posedge clk);
      q = 32'(rxc);
      repeat (8) @(posedge clk);
      chk(32'(q[0] ^ rxc), 32'h0);
      ena <= 1'b1;
      chk(32'(axo), 32'h1);
      apb(1'b1, 8'h6c, 32'ha000); w3(); chk(32'({axo, fsw}), 32'h1);
      mmx <= 1'b1;
      amx <= 1'b0;
      apb(1'b1, 8'h6c, 32'h0); w3(); chk(32'({axo, fsw}), 32'h1);
      apb(1'b1, 8'h78, 32'h80);
      nrg <= 1'b1;
      w3(); chk(32'(irq), 32'h1);
      ev <= 6'h08;
      @(posedge clk);
      ev <= 6'h00;
      apb(1'b0, 8'h74, 32'h0); chk(q, 32'h90);
      w3(); chk(32'(irq), 32'h0);
      fork
         apb(1'b0, 8'h74, 32'h0);
         begin
            @(posedge clk);
            ev <= 6'h01;
            @(posedge clk);
            ev <= 6'h00;
         end
      join
      chk(q, 32'h0);
      apb(1'b0, 8'h74, 32'h0); chk(q, 32'h2);
      apb(1'b1, 8'h00, 32'h2800); w3(); chk(32'(cen), 32'h0);
      apb(1'b1, 8'h00, 32'h2000); w3(); chk(32'(crst), 32'h1);
      apb(1'b0, 8'h78, 32'h0); chk(q, 32'h80);
      go <= 1'b1;
      nrg <= 1'b0;
      repeat (25) @(posedge clk);
      apb(1'b1, 8'h44, 32'h2000); w3(); chk(32'({cen, ltx}), 32'h0);
      nrg <= 1'b1;
      w3(); chk(32'({crst, irq}), 32'h3);
      apb(1'b0, 8'h74, 32'h0); chk(q, 32'h80);
      apb(1'b0, 8'h44, 32'h0); chk(q, 32'h2002);
      apb(1'b1, 8'h00, 32'h8000);
      apb(1'b0, 8'h00, 32'h0); chk(q, 32'h3000);
      rl <= 1'b1;
      @(posedge clk);
      rl <= 1'b0;
      apb(1'b0, 8'h00, 32'h0); chk(q, 32'h2000);
      ext <= 1'b1;
      repeat (30) @(posedge clk);
      chk(32'(cen), 32'h0);
      end_sim();
   end
endmodule
`default_nettype wire
